//--- mdio_pkg.sv
// constants shared by the discrete i/o and status lamp logic
`default_nettype none
package mdio_pkg;
   // -------------------------------------------------------------
   // sizes
   // -------------------------------------------------------------
   localparam int N_IN = 7;
   localparam int N_OUT = 3;
   localparam int REG_W = 16;
   localparam int CTL_W = 16;
   localparam int N_LAMP = 18;
   localparam int IRQ_W = 3;
   // -------------------------------------------------------------
   // register byte offsets
   // -------------------------------------------------------------
   localparam logic [7:0] OFF_IN_STATUS = 8'h00;
   localparam logic [7:0] OFF_OUT_CTRL = 8'h04;
   localparam logic [7:0] OFF_IO_MASK = 8'h08;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] OFF_IRQ_CLEAR = 8'h10;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;
   localparam logic [7:0] OFF_HEALTH = 8'h18;
   // -------------------------------------------------------------
   // fields and reset values
   // -------------------------------------------------------------
   localparam int IN_FAULT_BIT = 7;
   localparam int MASK_OUT_LSB = 8;
   localparam logic [15:0] MASK_RESET = 16'h0007;
   localparam logic [6:0] PREDEF_IN_OK = 7'h1f;
   localparam logic [2:0] PREDEF_OUT_OK = 3'h1;
   localparam logic [15:0] OUT_RESET = 16'h0000;
   localparam int CTL_ENABLE_BIT = 0;
   localparam int CTL_BRAKE_BIT = 1;
   localparam int IRQ_IN_CHANGE = 0;
   localparam int IRQ_FAULT = 1;
   localparam int IRQ_FAILURE = 2;
   // -------------------------------------------------------------
   // lamp positions
   // -------------------------------------------------------------
   localparam int LAMP_IN_LSB = 0;
   localparam int LAMP_FAULT = 7;
   localparam int LAMP_ENBL = 8;
   localparam int LAMP_OUT_LSB = 9;
   localparam int LAMP_BACKPLANE = 12;
   localparam int LAMP_MODULE_OK = 13;
   localparam int LAMP_POWER_OK = 14;
   localparam int LAMP_SERIAL = 15;
   localparam int LAMP_MOTION_IN_PROGRESS = 16;
   localparam int LAMP_IN_POS = 17;
   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLK_KHZ = 200000;
   localparam int BLINK_MS = 50;
   localparam int BLINK_CYC = BLINK_MS * CLK_KHZ;
endpackage
`default_nettype wire

//--- mdio_sync.sv
// two stage synchroniser for field inputs
`default_nettype none
`timescale 1ns/100ps
module mdio_sync #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] q_r;

   // first stage is read only by the second
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s1_r <= '0;
         q_r <= '0;
      end
      else
      begin
         s1_r <= d;
         q_r <= s1_r;
      end
   end

   assign q = q_r;
endmodule
`default_nettype wire

//--- mdio_blink.sv
// serial link lamp: lit while link is up, blinks on character traffic
`default_nettype none
`timescale 1ns/100ps
module mdio_blink #(
   parameter int HOLD_CYC = mdio_pkg::BLINK_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link state
   input wire logic link_up,
   input wire logic char_stb,
   // lamp
   output logic lamp
);
   typedef enum logic [2:0] {
      MDIO_BL_IDLE = 3'b001,
      MDIO_BL_DARK = 3'b010,
      MDIO_BL_LIT = 3'b100
   } mdio_blink_e;

   mdio_blink_e state_r;
   logic [31:0] cnt_r;
   logic pend_r;
   logic lamp_r;
   logic cnt_done;

   assign cnt_done = (cnt_r == 32'(HOLD_CYC - 1));

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_r <= MDIO_BL_IDLE;
         cnt_r <= '0;
      end
      else
      begin
         case (state_r)
            MDIO_BL_IDLE:
            begin
               cnt_r <= '0;
               if (char_stb && link_up)
                  state_r <= MDIO_BL_DARK;
            end
            MDIO_BL_DARK:
            begin
               cnt_r <= cnt_done ? '0 : cnt_r + 32'h1;
               if (cnt_done)
                  state_r <= MDIO_BL_LIT;
            end
            MDIO_BL_LIT:
            begin
               cnt_r <= cnt_done ? '0 : cnt_r + 32'h1;
               if (cnt_done)
                  state_r <= (pend_r && link_up) ? MDIO_BL_DARK
                                                 : MDIO_BL_IDLE;
            end
            default:
               state_r <= MDIO_BL_IDLE;
         endcase
      end
   end

   // traffic seen during a blink keeps it going
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         pend_r <= 1'b0;
      else if (state_r == MDIO_BL_LIT && cnt_done)
         pend_r <= 1'b0;
      else if (char_stb && state_r != MDIO_BL_IDLE)
         pend_r <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         lamp_r <= 1'b0;
      else
         lamp_r <= link_up && (state_r != MDIO_BL_DARK);
   end

   assign lamp = lamp_r;
endmodule
`default_nettype wire

//--- mdio_top.sv
// discrete i/o, status registers and front panel lamps of a motion axis
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`default_nettype none
`timescale 1ns/100ps
// Behaviour
// RULE1: seven general inputs, three outputs, plus a drive fault input.
// RULE2: input status bits 1-7 inputs, bit 8 drive fault, 9-16 reserved.
// RULE3: output register bits 1-3 outputs, output 1 is brake, rest reserved.
// RULE4: first five inputs each selectable as discrete or motion function.
// RULE5: any pin masked into an unsupported mode is disabled.
// RULE6: mode of inputs 1-3 resets predefined, inputs 4-5 discrete.
// RULE7: limit inputs read active while travel limit is not reached.
// RULE8: home input reads active while motor is away from home switch.
// RULE9: drive fault bit and lamp active whenever drive reports fault.
// RULE10: eighteen front panel lamps driven.
// RULE11: drive enable lamp lit exactly when enable output asserted.
// RULE12: serial lamp shows link up and blinks on character traffic.
// RULE13: healthy lamp lit until an internal failure is detected.
// RULE14: motion lamp lit while new position commands are issued.
// RULE15: in-position lamp lit while inside the in-position window.
// RULE16: link activity lamp lit while backplane link is active.
// RULE17: active control word is the OR of all interface words.
// RULE18: inputs pass two flip-flops before status or lamps.
// RULE19: reserved bits read zero and ignore writes.
module mdio_top #(
   parameter int BLINK_CYC = mdio_pkg::BLINK_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // field pins
   input wire logic [mdio_pkg::N_IN-1:0] din_pins,
   input wire logic servo_amp_fault,
   output logic [mdio_pkg::N_OUT-1:0] dout_pins,
   output logic servo_amp_on,
   // control words from each control interface
   input wire logic [mdio_pkg::CTL_W-1:0] ctl_backplane,
   input wire logic [mdio_pkg::CTL_W-1:0] ctl_serial,
   input wire logic [mdio_pkg::CTL_W-1:0] ctl_program,
   output logic [mdio_pkg::CTL_W-1:0] active_ctl,
   // status from the rest of the module
   input wire logic backplane_link_up,
   input wire logic serial_link_up,
   input wire logic serial_char_stb,
   input wire logic internal_failure,
   input wire logic power_good,
   input wire logic motion_in_progress,
   input wire logic in_position,
   // motion functions to the motion core
   output logic pos_limit_ok,
   output logic neg_limit_ok,
   output logic away_from_origin_switch,
   output logic jog_plus_req,
   output logic jog_minus_req,
   // lamps and interrupt
   output logic [mdio_pkg::N_LAMP-1:0] lamps,
   output logic irq
);
   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   logic [mdio_pkg::N_IN:0] raw_sync;
   logic [mdio_pkg::N_IN:0] in_stat_r;
   logic [mdio_pkg::N_IN:0] in_stat_nxt;
   logic [mdio_pkg::REG_W-1:0] out_r;
   logic [mdio_pkg::REG_W-1:0] mask_r;
   logic [mdio_pkg::IRQ_W-1:0] irq_stat_r;
   logic [mdio_pkg::IRQ_W-1:0] irq_en_r;
   logic [mdio_pkg::IRQ_W-1:0] irq_ev;
   logic [mdio_pkg::CTL_W-1:0] ctl_r;
   logic [mdio_pkg::N_OUT-1:0] dout_r;
   logic [mdio_pkg::N_LAMP-1:0] lamps_r;
   logic [4:0] func_r;
   logic amp_on_r;
   logic fault_seen_r;
   logic fail_seen_r;
   logic serial_lamp;
   logic ack_r;
   logic [31:0] rdat_r;
   logic req;
   logic wr_go;
   logic [6:0] in_dis;
   logic [2:0] out_dis;
   logic [1:0] warm_r;

   // write one register byte lane pair, reserved bits kept zero
   function automatic logic [15:0] lane_wr(input logic [15:0] cur,
                                           input logic [31:0] dat,
                                           input logic [3:0] sel,
                                           input logic [15:0] keep);
      logic [15:0] v;
      v = cur;
      if (sel[0])
         v[7:0] = dat[7:0];
      if (sel[1])
         v[15:8] = dat[15:8];
      return v & keep;
   endfunction

   // -------------------------------------------------------------
   // input synchronisation
   // -------------------------------------------------------------
   mdio_sync #(
      .W(mdio_pkg::N_IN + 1)
   ) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .d({servo_amp_fault, din_pins}),
      .q(raw_sync)
   ); // RULE18 RULE1

   // -------------------------------------------------------------
   // mode decode
   // -------------------------------------------------------------
   // predefined requested where not supported disables the pin
   assign in_dis = mask_r[6:0] & ~mdio_pkg::PREDEF_IN_OK; // RULE5
   assign out_dis = mask_r[mdio_pkg::MASK_OUT_LSB +: mdio_pkg::N_OUT]
                    & ~mdio_pkg::PREDEF_OUT_OK; // RULE5

   always_comb
   begin
      in_stat_nxt = raw_sync; // RULE2 RULE9
      in_stat_nxt[6:0] = raw_sync[6:0] & ~in_dis; // RULE5
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         in_stat_r <= '0;
      else
         in_stat_r <= in_stat_nxt; // RULE2
   end

   // motion functions only where the pin is predefined
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         func_r <= '0;
      else
         func_r <= raw_sync[4:0] & mask_r[4:0]; // RULE4 RULE7 RULE8
   end

   assign pos_limit_ok = func_r[0]; // RULE7
   assign neg_limit_ok = func_r[1]; // RULE7
   assign away_from_origin_switch = func_r[2]; // RULE8
   assign jog_plus_req = func_r[3];
   assign jog_minus_req = func_r[4];

   // -------------------------------------------------------------
   // control word and outputs
   // -------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ctl_r <= '0;
      else
         ctl_r <= ctl_backplane | ctl_serial | ctl_program; // RULE17
   end

   assign active_ctl = ctl_r;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         amp_on_r <= 1'b0;
      else
         amp_on_r <= ctl_r[mdio_pkg::CTL_ENABLE_BIT];
   end

   assign servo_amp_on = amp_on_r;

   // output 1 in predefined mode follows the brake release bit
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         dout_r <= '0;
      else
      begin
         dout_r <= out_r[mdio_pkg::N_OUT-1:0] & ~out_dis; // RULE3 RULE5
         if (mask_r[mdio_pkg::MASK_OUT_LSB])
            dout_r[0] <= ctl_r[mdio_pkg::CTL_BRAKE_BIT]; // RULE3
      end
   end

   assign dout_pins = dout_r;

   // -------------------------------------------------------------
   // lamps
   // -------------------------------------------------------------
   mdio_blink #(
      .HOLD_CYC(BLINK_CYC)
   ) u_blink (
      .clk(clk),
      .sys_rst(sys_rst),
      .link_up(serial_link_up),
      .char_stb(serial_char_stb),
      .lamp(serial_lamp)
   ); // RULE12

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         lamps_r <= '0;
      else
      begin
         lamps_r[mdio_pkg::LAMP_IN_LSB +: 7] <= in_stat_nxt[6:0]; // RULE10
         lamps_r[mdio_pkg::LAMP_FAULT] <= raw_sync[7]; // RULE9
         lamps_r[mdio_pkg::LAMP_ENBL] <=
            ctl_r[mdio_pkg::CTL_ENABLE_BIT]; // RULE11
         lamps_r[mdio_pkg::LAMP_OUT_LSB +: 3] <= dout_r;
         lamps_r[mdio_pkg::LAMP_BACKPLANE] <= backplane_link_up; // RULE16
         lamps_r[mdio_pkg::LAMP_MODULE_OK] <=
            ~(internal_failure | fail_seen_r); // RULE13
         lamps_r[mdio_pkg::LAMP_POWER_OK] <= power_good;
         lamps_r[mdio_pkg::LAMP_SERIAL] <= serial_lamp; // RULE12
         lamps_r[mdio_pkg::LAMP_MOTION_IN_PROGRESS] <= motion_in_progress; // RULE14
         lamps_r[mdio_pkg::LAMP_IN_POS] <= in_position; // RULE15
      end
   end

   assign lamps = lamps_r;

   // failure is latched until reset
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         fail_seen_r <= 1'b0;
      else if (internal_failure)
         fail_seen_r <= 1'b1; // RULE13
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         fault_seen_r <= 1'b0;
      else
         fault_seen_r <= raw_sync[7];
   end

   // -------------------------------------------------------------
   // wishbone slave
   // -------------------------------------------------------------
   assign req = wb_cyc_i && wb_stb_i;
   assign wr_go = req && wb_we_i && ack_r;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ack_r <= 1'b0;
      else
         ack_r <= req && !ack_r;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdat_r <= '0;
      else if (req && !ack_r)
      begin
         case (wb_adr_i)
            mdio_pkg::OFF_IN_STATUS: rdat_r <= 32'(in_stat_r); // RULE19
            mdio_pkg::OFF_OUT_CTRL: rdat_r <= 32'(out_r);
            mdio_pkg::OFF_IO_MASK: rdat_r <= 32'(mask_r);
            mdio_pkg::OFF_IRQ_STATUS: rdat_r <= 32'(irq_stat_r);
            mdio_pkg::OFF_IRQ_ENABLE: rdat_r <= 32'(irq_en_r);
            mdio_pkg::OFF_HEALTH: rdat_r <= 32'(lamps_r);
            default: rdat_r <= '0;
         endcase
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         out_r <= mdio_pkg::OUT_RESET;
      else if (wr_go && wb_adr_i == mdio_pkg::OFF_OUT_CTRL)
         out_r <= lane_wr(out_r, wb_dat_i, wb_sel_i, 16'h0007); // RULE19
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         mask_r <= mdio_pkg::MASK_RESET; // RULE6
      else if (wr_go && wb_adr_i == mdio_pkg::OFF_IO_MASK)
         mask_r <= lane_wr(mask_r, wb_dat_i, wb_sel_i, 16'h077f); // RULE4
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         irq_en_r <= '0;
      else if (wr_go && wb_adr_i == mdio_pkg::OFF_IRQ_ENABLE && wb_sel_i[0])
         irq_en_r <= wb_dat_i[mdio_pkg::IRQ_W-1:0];
   end

   // -------------------------------------------------------------
   // interrupts
   // -------------------------------------------------------------
   always_comb
   begin
      irq_ev = '0;
      irq_ev[mdio_pkg::IRQ_IN_CHANGE] = (in_stat_nxt != in_stat_r);
      irq_ev[mdio_pkg::IRQ_FAULT] = raw_sync[7] && !fault_seen_r;
      irq_ev[mdio_pkg::IRQ_FAILURE] = internal_failure && !fail_seen_r;
   end

   // a new event wins over a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         irq_stat_r <= '0;
      else if (wr_go && wb_adr_i == mdio_pkg::OFF_IRQ_CLEAR && wb_sel_i[0])
         irq_stat_r <= (irq_stat_r & ~wb_dat_i[mdio_pkg::IRQ_W-1:0])
                       | irq_ev;
      else
         irq_stat_r <= irq_stat_r | irq_ev;
   end

   assign irq = |(irq_stat_r & irq_en_r);

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         warm_r <= '0;
      else if (warm_r != 2'h3)
         warm_r <= warm_r + 2'h1;
   end

   sequence s_req_open;
      req && !ack_r;
   endsequence

   sequence s_ack_pulse;
      ack_r ##1 !ack_r;
   endsequence

   a_ack_timing: assert property (@(posedge clk) disable iff (sys_rst)
      s_req_open |=> s_ack_pulse)
      else $error("ack not one cycle after request");
   a_input_path: assert property (@(posedge clk) disable iff (sys_rst) // RULE18
      warm_r == 2'h3 |-> in_stat_r[0] == $past(din_pins[0], 3))
      else $error("input 1 status not three cycles behind pin");
   a_fault_bit: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
      warm_r == 2'h3 |-> in_stat_r[mdio_pkg::IN_FAULT_BIT]
         == $past(servo_amp_fault, 3))
      else $error("drive fault bit does not follow pin");
   a_enable_lamp: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
      lamps_r[mdio_pkg::LAMP_ENBL] == amp_on_r)
      else $error("enable lamp differs from enable output");
   a_ctl_or: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
      ##1 active_ctl == $past(ctl_backplane | ctl_serial | ctl_program))
      else $error("active control word is not the or");
   a_in6_disable: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
      mask_r[5] |=> !in_stat_r[5])
      else $error("input 6 in predefined mode not disabled");
   a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst) // RULE19
      out_r[15:3] == '0 && mask_r[15:11] == '0 && mask_r[7] == 1'b0)
      else $error("reserved bits not zero");
   a_mode_default: assert property (@(posedge clk) // RULE6
      $fell(sys_rst) |-> mask_r[4:0] == 5'h07)
      else $error("mode selection reset default wrong");
   a_module_ok: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
      internal_failure |=> ##1 !lamps_r[mdio_pkg::LAMP_MODULE_OK] [*3])
      else $error("health lamp lit after failure");
   a_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
      irq_ev[mdio_pkg::IRQ_FAULT] |=> irq_stat_r[mdio_pkg::IRQ_FAULT])
      else $error("fault event lost");
   a_lamp_follow: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
      ##1 lamps_r[mdio_pkg::LAMP_MOTION_IN_PROGRESS] == $past(motion_in_progress)
      && lamps_r[mdio_pkg::LAMP_IN_POS] == $past(in_position) // RULE15
      && lamps_r[mdio_pkg::LAMP_BACKPLANE] == $past(backplane_link_up))
      else $error("status lamp does not follow its source"); // RULE16
endmodule
`default_nettype wire

//--- mdio_field.sv
// field switch and servo drive model facing the discrete i/o block
`timescale 1ns/100ps
`default_nettype none
module mdio_field (
   // clock
   input wire logic clk,
   // field side
   output logic [6:0] din_pins,
   output logic servo_amp_fault,
   input wire logic servo_amp_on
);
   logic [6:0] sw_r = 7'h00;
   logic flt_r = 1'b0;
   logic on_seen_r = 1'b0;
   // switch levels and drive fault move just after an edge
   task automatic set_sw(input logic [6:0] v, input logic f);
      @(posedge clk);
      sw_r <= v;
      flt_r <= f;
   endtask
   // drive remembers that it was ever enabled
   always_ff @(posedge clk)
   begin
      if (servo_amp_on === 1'b1)
         on_seen_r <= 1'b1;
   end
   assign din_pins = sw_r;
   assign servo_amp_fault = flt_r;
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for the discrete i/o and lamp block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0] sel = 4'h0;
   logic [3:0] lane = 4'h3;
   logic [31:0] rdat;
   logic [31:0] q;
   logic ack;
   logic [6:0] din;
   logic flt;
   logic [2:0] dout;
   logic amp_on;
   logic [15:0] ctl_b = 16'h0;
   logic [15:0] ctl_s = 16'h0;
   logic [15:0] ctl_p = 16'h0;
   logic [15:0] act;
   logic bl_up = 1'b0;
   logic sl_up = 1'b0;
   logic chr = 1'b0;
   logic fail = 1'b0;
   logic pgood = 1'b0;
   logic mov = 1'b0;
   logic inpos = 1'b0;
   logic pl, nl, away, jp, jm, irq;
   logic [17:0] lamps;
   int err_count = 0;
   int checked = 0;
   always #2.5 clk = ~clk;
   mdio_field fld (.clk(clk), .din_pins(din), .servo_amp_fault(flt),
      .servo_amp_on(amp_on));
   mdio_top #(.BLINK_CYC(4)) dut (.clk(clk), .sys_rst(sys_rst),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .din_pins(din), .servo_amp_fault(flt), .dout_pins(dout),
      .servo_amp_on(amp_on), .ctl_backplane(ctl_b), .ctl_serial(ctl_s),
      .ctl_program(ctl_p), .active_ctl(act), .backplane_link_up(bl_up),
      .serial_link_up(sl_up), .serial_char_stb(chr),
      .internal_failure(fail), .power_good(pgood),
      .motion_in_progress(mov), .in_position(inpos), .pos_limit_ok(pl),
      .neg_limit_ok(nl), .away_from_origin_switch(away),
      .jog_plus_req(jp), .jog_minus_req(jm), .lamps(lamps), .irq(irq));
   // -----------------------------------------------------------------
   // tasks
   // -----------------------------------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // classic cycle: hold until ack is sampled, then release
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= lane;
      do
      begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1)
      begin
         err_count++;
         $display("mismatch at %0t: no bus ack", $time);
      end
      q = rdat;
      cyc <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   // -----------------------------------------------------------------
   // tests
   // -----------------------------------------------------------------
   initial
   begin
      tick(5);
      sys_rst <= 1'b0;
      rd(8'h08, 32'h00000007);
      rd(8'h04, 32'h00000000);
      rd(8'h1c, 32'h00000000);
      wr(8'h14, 32'h00000002);
      wr(8'h10, 32'h00000007);
      chk(32'(irq), 32'h0);
      fld.set_sw(7'h55, 1'b1);
      tick(5);
      rd(8'h00, 32'h000000d5);
      chk(32'(lamps[7:0]), 32'hd5);
      chk(32'(irq), 32'h1);
      rd(8'h0c, 32'h00000003);
      wr(8'h10, 32'h00000002);
      tick(2);
      chk(32'(irq), 32'h0);
      rd(8'h0c, 32'h00000001);
      wr(8'h14, 32'h00000000);
      wr(8'h08, 32'h0000001f);
      tick(4);
      chk(32'({pl, nl, away, jp, jm}), 32'h15);
      wr(8'h08, 32'h00000000);
      tick(4);
      chk(32'({pl, nl, away, jp, jm}), 32'h0);
      wr(8'h08, 32'h0000ff60);
      rd(8'h08, 32'h00000760);
      wr(8'h04, 32'h0000ffff);
      rd(8'h04, 32'h00000007);
      lane = 4'h2;
      wr(8'h04, 32'h00000000);
      lane = 4'h3;
      rd(8'h04, 32'h00000007);
      tick(4);
      rd(8'h00, 32'h00000095);
      chk(32'(dout), 32'h0);
      ctl_s <= 16'h0002;
      ctl_p <= 16'h8001;
      tick(3);
      chk(32'(act), 32'h8003);
      chk(32'({dout[0], amp_on, lamps[8]}), 32'h7);
      wr(8'h08, 32'h00000000);
      ctl_s <= 16'h0000;
      ctl_p <= 16'h0000;
      tick(3);
      chk(32'({lamps[11:9], dout, amp_on, lamps[8]}), 32'hfc);
      chk(32'(fld.on_seen_r), 32'h1);
      bl_up <= 1'b1;
      pgood <= 1'b1;
      mov <= 1'b1;
      inpos <= 1'b1;
      sl_up <= 1'b1;
      tick(3);
      chk(32'(lamps[17:12]), 32'h3f);
      chr <= 1'b1;
      tick(1);
      chr <= 1'b0;
      tick(3);
      chk(32'(lamps[15]), 32'h0);
      tick(8);
      chk(32'(lamps[15]), 32'h1);
      fail <= 1'b1;
      tick(3);
      fail <= 1'b0;
      tick(3);
      chk(32'(lamps[13]), 32'h0);
      bl_up <= 1'b0;
      sl_up <= 1'b0;
      mov <= 1'b0;
      inpos <= 1'b0;
      tick(3);
      chk(32'({lamps[17:15], lamps[12]}), 32'h0);
      rd(8'h18, 32'h00004ed5);
      wrap_up();
   end
   initial
   begin
      #100000;
      err_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
